// File: shared/lcs_pkg.sv
// Package: constants for the scan driver block
package lcs_pkg;
   // ***********************************************
   // Geometry
   // ***********************************************
   localparam int ROWS = 100;
   localparam int HALF = 50;
   localparam int BYP = 10;
   localparam int LVL_W = 2;
   // ***********************************************
   // Bias level codes on the row drive outputs
   // ***********************************************
   localparam logic [1:0] LVL_ONE = 2'h0;
   localparam logic [1:0] LVL_TWO = 2'h1;
   localparam logic [1:0] LVL_THREE = 2'h2;
   localparam logic [1:0] LVL_FOUR = 2'h3;
   // ***********************************************
   // Reset values and timing
   // ***********************************************
   localparam logic [ROWS-1:0] SR_RST = 100'h0;
   localparam int CLK_SYS_HZ = 20_000_000;
   localparam int SHIFT_CLK_MAX_HZ = 1_000_000;
   localparam int CYC_PER_SHIFT = CLK_SYS_HZ / SHIFT_CLK_MAX_HZ;
endpackage : lcs_pkg

// File: shared/lcs_lvl_if.sv
// Interface: scan bits and frame controls to the level selector
`timescale 1ns/1ps
`default_nettype none
interface lcs_lvl_if;
   import lcs_pkg::*;
   logic [ROWS-1:0] row_bits;
   logic frame_ac_sync;
   logic output_blank_n;
   logic [ROWS-1:0][LVL_W-1:0] row_level;
   modport scan (output row_bits, output frame_ac_sync,
      output output_blank_n, input row_level);
   modport sel (input row_bits, input frame_ac_sync,
      input output_blank_n, output row_level);
endinterface : lcs_lvl_if
`default_nettype wire

// File: rtl/lcs_level_sel.sv
// Level selector: per-row bias level from scan bit, frame and blanking
`timescale 1ns/1ps
`default_nettype none
module lcs_level_sel (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   lcs_lvl_if.sel lvl
);
   import lcs_pkg::*;
   logic [ROWS-1:0][LVL_W-1:0] lvl_reg;
   logic [ROWS-1:0][LVL_W-1:0] lvl_next;

   // ***********************************************
   // Per-row selection
   // ***********************************************
   for (genvar g = 0; g < ROWS; g++) begin : g_row
      always_comb begin
         if (!lvl.output_blank_n) begin
            lvl_next[g] = LVL_ONE;
         end else begin
            unique case ({lvl.frame_ac_sync, lvl.row_bits[g]})
               2'h0: lvl_next[g] = LVL_TWO;
               2'h1: lvl_next[g] = LVL_FOUR;
               2'h2: lvl_next[g] = LVL_THREE;
               2'h3: lvl_next[g] = LVL_ONE;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         lvl_reg <= '0;
      end else begin
         lvl_reg <= lvl_next;
      end
   end

   assign lvl.row_level = lvl_reg;

   // ***********************************************
   // Checks
   // ***********************************************
   chk_blank_all_one: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      !lvl.output_blank_n |=> (lvl_reg == '0))
      else $error("blanking did not force level one");
   chk_level_map_lo: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      lvl.output_blank_n && !lvl.frame_ac_sync && lvl.row_bits[0]
      |=> lvl_reg[0] == LVL_FOUR)
      else $error("frame low bit high not level four");
   chk_level_map_hi: assert property (
      @(posedge i_clk_sys) disable iff (i_rst)
      lvl.output_blank_n && lvl.frame_ac_sync && !lvl.row_bits[99]
      |=> lvl_reg[99] == LVL_THREE)
      else $error("frame high bit low not level three");
endmodule : lcs_level_sel
`default_nettype wire

// File: rtl/lcs_scan_driver.sv
// Scan driver top: two 50-bit bidirectional scan shifters and pins
`timescale 1ns/1ps
`default_nettype none
module lcs_scan_driver (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_shift_clock,
   input wire logic i_shift_dir_sel,
   input wire logic i_bypass_sel_low_half,
   input wire logic i_bypass_sel_high_half,
   input wire logic i_frame_ac_sync,
   input wire logic i_output_blank_n,
   input wire logic i_scan_io_first,
   input wire logic i_scan_io_low_end,
   input wire logic i_scan_io_high_start,
   input wire logic i_scan_io_last,
   output logic o_scan_io_first,
   output logic o_scan_io_first_oe,
   output logic o_scan_io_low_end,
   output logic o_scan_io_low_end_oe,
   output logic o_scan_io_high_start,
   output logic o_scan_io_high_start_oe,
   output logic o_scan_io_last,
   output logic o_scan_io_last_oe,
   output logic [lcs_pkg::ROWS-1:0][lcs_pkg::LVL_W-1:0] o_row_drive_out
);
   import lcs_pkg::*;

   // ***********************************************
   // Pin synchronisers
   // ***********************************************
   // Bit order: clk dir bl bh frame blank first lowend highstart last
   localparam int NSYNC = 10;
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] sync1_reg;
   logic [NSYNC-1:0] sync1_next;
   logic [NSYNC-1:0] sync2_reg;
   logic [NSYNC-1:0] sync2_next;
   logic clk_prev_reg;
   logic clk_prev_next;
   logic fall;
   logic clk_s, dir_s, bl_s, bh_s, frame_s, blank_s;
   logic in_first, in_low_end, in_high_start, in_last;

   assign pins = {i_shift_clock, i_shift_dir_sel, i_bypass_sel_low_half,
      i_bypass_sel_high_half, i_frame_ac_sync, i_output_blank_n,
      i_scan_io_first, i_scan_io_low_end, i_scan_io_high_start,
      i_scan_io_last};

   always_comb begin
      sync1_next = pins;
      sync2_next = sync1_reg;
      clk_prev_next = clk_s;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         clk_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         clk_prev_reg <= clk_prev_next;
      end
   end

   assign {clk_s, dir_s, bl_s, bh_s, frame_s, blank_s,
      in_first, in_low_end, in_high_start, in_last} = sync2_reg;
   // Data and clock share the same sync depth, so setup and hold carry over
   assign fall = clk_prev_reg & ~clk_s;

   // ***********************************************
   // Scan shifters
   // ***********************************************
   logic [ROWS-1:0] sr_reg;
   logic [ROWS-1:0] sr_next;

   always_comb begin
      sr_next = sr_reg;
      if (fall) begin
         if (!dir_s) begin
            // Skipped rows are cleared so they never select a row
            if (bl_s) begin
               sr_next[HALF-1:0] = {sr_reg[HALF-2:BYP], in_first,
                  {BYP{1'b0}}};
            end else begin
               sr_next[HALF-1:0] = {sr_reg[HALF-2:0], in_first};
            end
            sr_next[ROWS-1:HALF] = {sr_reg[ROWS-2:HALF],
               in_high_start};
         end else begin
            sr_next[HALF-1:0] = {in_low_end, sr_reg[HALF-1:1]};
            if (bh_s) begin
               sr_next[ROWS-1:HALF] = {{BYP{1'b0}}, in_last,
                  sr_reg[ROWS-BYP-1:HALF+1]};
            end else begin
               sr_next[ROWS-1:HALF] = {in_last,
                  sr_reg[ROWS-1:HALF+1]};
            end
         end
      end
   end

   // ***********************************************
   // Scan pin drive direction
   // ***********************************************
   logic [3:0] oe_reg;
   logic [3:0] oe_next;

   always_comb begin
      // Direction select is static, so one sync path is enough
      oe_next = dir_s ? 4'hA : 4'h5;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sr_reg <= SR_RST;
         oe_reg <= 4'h0;
      end else begin
         sr_reg <= sr_next;
         oe_reg <= oe_next;
      end
   end

   // oe bits: 3 first, 2 low end, 1 high start, 0 last
   assign o_scan_io_first = sr_reg[0];
   assign o_scan_io_low_end = sr_reg[HALF-1];
   assign o_scan_io_high_start = sr_reg[HALF];
   assign o_scan_io_last = sr_reg[ROWS-1];
   assign o_scan_io_first_oe = oe_reg[3];
   assign o_scan_io_low_end_oe = oe_reg[2];
   assign o_scan_io_high_start_oe = oe_reg[1];
   assign o_scan_io_last_oe = oe_reg[0];

   // ***********************************************
   // Level selection
   // ***********************************************
   lcs_lvl_if lvl_bus ();

   assign lvl_bus.row_bits = sr_reg;
   assign lvl_bus.frame_ac_sync = frame_s;
   assign lvl_bus.output_blank_n = blank_s;
   assign o_row_drive_out = lvl_bus.row_level;

   lcs_level_sel u_level_sel (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .lvl(lvl_bus.sel)
   );

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   chk_hold_no_fall: assert property (
      !fall |=> $stable(sr_reg))
      else $error("shifter moved without a clock fall");
   chk_up_low_shift: assert property (
      fall && !dir_s && !bl_s |=>
      sr_reg[HALF-1:0] == {$past(sr_reg[HALF-2:0]), $past(in_first)})
      else $error("lower upward shift wrong");
   chk_up_high_shift: assert property (
      fall && !dir_s |=>
      sr_reg[ROWS-1:HALF] == {$past(sr_reg[ROWS-2:HALF]),
      $past(in_high_start)})
      else $error("upper upward shift wrong");
   chk_down_low_shift: assert property (
      fall && dir_s |=>
      sr_reg[HALF-1:0] == {$past(in_low_end), $past(sr_reg[HALF-1:1])})
      else $error("lower downward shift wrong");
   chk_bypass_low_load: assert property (
      fall && !dir_s && bl_s |=>
      sr_reg[BYP] == $past(in_first) && sr_reg[BYP-1:0] == '0)
      else $error("low bypass load wrong");
   chk_bypass_high_load: assert property (
      fall && dir_s && bh_s |=>
      sr_reg[ROWS-BYP-1] == $past(in_last) && sr_reg[ROWS-1:ROWS-BYP] == '0)
      else $error("high bypass load wrong");
   // Enable checks wait a cycle: the enables lag the synced select
   chk_pin_dir_out: assert property (
      dir_s ##1 dir_s |-> o_scan_io_first_oe && !o_scan_io_last_oe
      && o_scan_io_high_start_oe && !o_scan_io_low_end_oe)
      else $error("scan pin drive direction wrong");
   chk_pin_dir_up: assert property (
      !dir_s ##1 !dir_s |-> o_scan_io_low_end_oe && o_scan_io_last_oe
      && !o_scan_io_first_oe && !o_scan_io_high_start_oe)
      else $error("upward scan pin drive direction wrong");
   chk_oe_pair: assert property (
      1'b1 |=> o_scan_io_first_oe == o_scan_io_high_start_oe
      && o_scan_io_low_end_oe == o_scan_io_last_oe
      && o_scan_io_first_oe != o_scan_io_low_end_oe)
      else $error("scan pin enables not one end per chain");
   chk_ends_hold: assert property (
      !fall |=> $stable({o_scan_io_first, o_scan_io_low_end,
      o_scan_io_high_start, o_scan_io_last}))
      else $error("scan pin output moved without a clock fall");
   chk_down_high_shift: assert property (
      fall && dir_s && !bh_s |=>
      sr_reg[ROWS-1:HALF] == {$past(in_last), $past(sr_reg[ROWS-1:HALF+1])})
      else $error("upper downward shift wrong");

   cov_upward: cover property (fall && !dir_s && !bl_s && in_first);
   cov_downward: cover property (fall && dir_s && !bh_s && in_last);
   cov_bypass_low: cover property (fall && !dir_s && bl_s);
   cov_bypass_high: cover property (fall && dir_s && bh_s);
   cov_blanked_shift: cover property (fall && !blank_s);
endmodule : lcs_scan_driver
`default_nettype wire

// File: verif/lcs_ctrl_model.sv
// Controller model: shift clock, scan data, frame and blanking drive
`timescale 1ns/1ps
`default_nettype none
module lcs_ctrl_model (
   input wire logic i_clk_sys,
   input wire logic i_dir,
   output logic o_shift_clock = 1'h0,
   output logic o_frame_ac_sync = 1'h0,
   output logic o_output_blank_n = 1'h1,
   output logic [3:0] o_scan
);
   logic junk = 1'h0;
   logic [1:0] dat = 2'h0;
   always @(negedge i_clk_sys) junk <= ~junk;
   // Pins owned by the device see a toggling value, never a stale one
   always_comb begin
      o_scan = {4{junk}};
      if (i_dir) begin
         o_scan[1] = dat[0];
         o_scan[3] = dat[1];
      end else begin
         o_scan[0] = dat[0];
         o_scan[2] = dat[1];
      end
   end
   // Data set at the rise, held four cycles past the fall
   task automatic pulse(input logic [1:0] d, input logic f, input logic bn);
      @(negedge i_clk_sys);
      dat = d;
      o_frame_ac_sync = f;
      o_output_blank_n = bn;
      o_shift_clock = 1'h1;
      repeat (4) @(negedge i_clk_sys);
      o_shift_clock = 1'h0;
      repeat (4) @(negedge i_clk_sys);
   endtask : pulse
endmodule : lcs_ctrl_model
`default_nettype wire

// File: verif/lcs_scan_driver_bench.sv
// Testbench: scan shifting, level selection and pin direction
`timescale 1ns/1ps
`default_nettype none
module lcs_scan_driver_bench;
   import lcs_pkg::*;
   logic clk = 1'h0, rst = 1'h1, dir = 1'h0, byl = 1'h0, byh = 1'h0;
   logic sck, frm, bln;
   logic [3:0] drv, pin;
   wire [3:0] o_s, o_oe;
   logic [ROWS-1:0][LVL_W-1:0] rows, exp_rows;
   logic [ROWS-1:0] ref_sr;
   logic [2:0] modes [6] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h1, 3'h6};
   int failures = 0, n_checks = 0;
   initial forever #25 clk = ~clk;
   // Wire level: device wins where its enable is up
   assign pin = (o_oe & o_s) | (~o_oe & drv);
   lcs_ctrl_model ctrl_u (.i_clk_sys(clk), .i_dir(dir),
      .o_shift_clock(sck), .o_frame_ac_sync(frm),
      .o_output_blank_n(bln), .o_scan(drv));
   lcs_scan_driver dut_u (.i_clk_sys(clk), .i_rst(rst),
      .i_shift_clock(sck), .i_shift_dir_sel(dir),
      .i_bypass_sel_low_half(byl), .i_bypass_sel_high_half(byh),
      .i_frame_ac_sync(frm), .i_output_blank_n(bln),
      .i_scan_io_first(pin[0]), .i_scan_io_low_end(pin[1]),
      .i_scan_io_high_start(pin[2]), .i_scan_io_last(pin[3]),
      .o_scan_io_first(o_s[0]), .o_scan_io_first_oe(o_oe[0]),
      .o_scan_io_low_end(o_s[1]), .o_scan_io_low_end_oe(o_oe[1]),
      .o_scan_io_high_start(o_s[2]), .o_scan_io_high_start_oe(o_oe[2]),
      .o_scan_io_last(o_s[3]), .o_scan_io_last_oe(o_oe[3]),
      .o_row_drive_out(rows));
   // ***********************************************
   // Helpers
   // ***********************************************
   task automatic check(input string name, input logic [199:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   function automatic logic [1:0] lvl(input logic f, b, bn);
      if (!bn) return LVL_ONE;
      return f ? (b ? LVL_ONE : LVL_THREE) : (b ? LVL_FOUR : LVL_TWO);
   endfunction : lvl
   // Reference shifter, index 0 is row 1; skipped rows read zero
   task automatic step(input logic [1:0] d);
      logic [49:0] lo, hi;
      if (!dir) begin
         lo = {ref_sr[48:0], d[0]};
         hi = {ref_sr[98:50], d[1]};
         if (byl) begin
            lo[10] = d[0];
            lo[9:0] = '0;
         end
      end else begin
         lo = {d[0], ref_sr[49:1]};
         hi = {d[1], ref_sr[99:51]};
         if (byh) begin
            hi[39] = d[1];
            hi[49:40] = '0;
         end
      end
      ref_sr = {hi, lo};
   endtask : step
   // ***********************************************
   // Tests: six of the eight select modes, reset between as at power-on
   // ***********************************************
   initial begin
      logic [1:0] d;
      logic f, bn;
      logic [3:0] scan_ends;
      foreach (modes[m]) begin
         @(negedge clk);
         rst = 1'h1;
         {dir, byl, byh} = modes[m];
         ref_sr = '0;
         @(negedge clk);
         check("reset rows", 200'(rows), '0);
         check("reset oe", 200'(o_oe), '0);
         repeat (6) @(negedge clk);
         rst = 1'h0;
         repeat (8) @(negedge clk);
         for (int k = 0; k < 60; k++) begin
            d = {k % 5 == 1, k % 7 == 0};
            f = k[0];
            bn = (k % 13 != 5);
            ctrl_u.pulse(d, f, bn);
            step(d);
            for (int r = 0; r < ROWS; r++) exp_rows[r] = lvl(f, ref_sr[r], bn);
            scan_ends = {ref_sr[99], ref_sr[50], ref_sr[49], ref_sr[0]};
            check("row levels", 200'(rows), 200'(exp_rows));
            check("scan out", 200'(o_s), 200'(scan_ends));
            check("scan oe", 200'(o_oe), 200'({~dir, dir, ~dir, dir}));
         end
      end
      end_of_test();
   end
   // Six modes of about 550 cycles each fit well inside this span
   initial begin
      #1_000_000;
      failures++;
      end_of_test();
   end
endmodule : lcs_scan_driver_bench
`default_nettype wire
